// ==== design/sys_desc_defines.svh ====
`ifndef SYS_DESC_DEFINES_SVH
`define SYS_DESC_DEFINES_SVH

// Type codes of system descriptors
`define TYPE_INVALID_LO     4'h0
`define TYPE_TSS_LEG_AVAIL  4'h1
`define TYPE_LDT            4'h2
`define TYPE_TSS_LEG_BUSY   4'h3
`define TYPE_CALL_LEG       4'h4
`define TYPE_TASK_GATE      4'h5
`define TYPE_INT_LEG        4'h6
`define TYPE_TRAP_LEG       4'h7
`define TYPE_INVALID_HI     4'h8
`define TYPE_TSS_EXT_AVAIL  4'h9
`define TYPE_RSVD_A         4'ha
`define TYPE_TSS_EXT_BUSY   4'hb
`define TYPE_CALL_EXT       4'hc
`define TYPE_RSVD_D         4'hd
`define TYPE_INT_EXT        4'he
`define TYPE_TRAP_EXT       4'hf

// Field positions in the second doubleword
`define HI_TYPE_LSB         8
`define HI_SYS_BIT          12
`define HI_DPL_LSB          13
`define HI_PRESENT_BIT      15
`define HI_G_BIT            23
`define HI_WCOUNT_LSB       0

// Exception vectors
`define EXC_NOT_PRESENT     8'h0b
`define EXC_GENERAL         8'h0d

// Page scaling of the limit
`define PAGE_SHIFT          12

// Register map
`define ADDR_CTRL           4'h0
`define ADDR_DESC_LO        4'h1
`define ADDR_DESC_HI        4'h2
`define ADDR_TASK_SEL       4'h3
`define ADDR_LOCAL_SEL      4'h4
`define ADDR_STATUS         4'h5
`define ADDR_BASE           4'h6
`define ADDR_LIMIT          4'h7
`define ADDR_ENTRY_SEL      4'h8
`define ADDR_ENTRY_OFS      4'h9
`define ADDR_COPY_INFO      4'ha
`define ADDR_TARGET         4'hb

`endif

// ==== design/sys_desc_pkg.sv ====
package sys_desc_pkg;
    typedef enum logic [3:0] {
        CLASS_NONE = 4'b0001,
        CLASS_TSS  = 4'b0010,
        CLASS_LDT  = 4'b0100,
        CLASS_GATE = 4'b1000
    } desc_class_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CHECK = 3'b010,
        ST_DONE  = 3'b100
    } check_state_t;
endpackage : sys_desc_pkg

// ==== design/desc_field_if.sv ====
`timescale 1ns/1ps
// Raw descriptor words and decoded fields between the top and the field extractor
interface desc_field_if;
    logic [31:0] word_lo;
    logic [31:0] word_hi;
    logic [31:0] base;
    logic [31:0] limit_bytes;
    logic [3:0]  dtype;
    logic        sys_flag;
    logic [1:0]  descriptor_privilege_level;
    logic        present;
    logic        legacy;
    logic [4:0]  word_count;
    logic [15:0] dest_sel;
    logic [31:0] dest_ofs;
    modport src (output word_lo, output word_hi,
                 input base, input limit_bytes, input dtype, input sys_flag,
                 input descriptor_privilege_level, input present, input legacy, input word_count,
                 input dest_sel, input dest_ofs);
    modport ext (input word_lo, input word_hi,
                 output base, output limit_bytes, output dtype, output sys_flag,
                 output descriptor_privilege_level, output present, output legacy, output word_count,
                 output dest_sel, output dest_ofs);
endinterface : desc_field_if

// ==== design/desc_field_extract.sv ====
`timescale 1ns/1ps
`include "sys_desc_defines.svh"
// Pure combinational split of an 8-byte descriptor into its fields
module desc_field_extract (
    desc_field_if.ext f
);
    logic [19:0] raw_limit;
    logic        gran;

    // Legacy entries have an all-zero upper half in the second word
    assign f.legacy   = (f.word_hi[31:16] == 16'h0000);
    assign f.dtype    = f.word_hi[`HI_TYPE_LSB +: 4];
    assign f.sys_flag = f.word_hi[`HI_SYS_BIT];
    assign f.descriptor_privilege_level      = f.word_hi[`HI_DPL_LSB +: 2];
    assign f.present  = f.word_hi[`HI_PRESENT_BIT];
    assign f.word_count = f.word_hi[`HI_WCOUNT_LSB +: 5];
    assign f.dest_sel = f.word_lo[31:16];

    // Legacy offset is 16 bits; extended takes the upper half from word two
    assign f.dest_ofs = f.legacy ? {16'h0000, f.word_lo[15:0]}
                                 : {f.word_hi[31:16], f.word_lo[15:0]};

    // Base: 24 bits legacy, 32 bits extended
    assign f.base = f.legacy ? {8'h00, f.word_hi[7:0], f.word_lo[31:16]}
                             : {f.word_hi[31:24], f.word_hi[7:0], f.word_lo[31:16]};

    assign raw_limit = f.legacy ? {4'h0, f.word_lo[15:0]}
                                : {f.word_hi[19:16], f.word_lo[15:0]};
    assign gran = ~f.legacy & f.word_hi[`HI_G_BIT];

    // Page granularity scales the limit to 4K pages, low bits filled with ones
    assign f.limit_bytes = gran ? {raw_limit, 12'hfff} : {12'h000, raw_limit};
endmodule : desc_field_extract

// ==== design/system_descriptor_decoder.sv ====
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sys_desc_defines.svh"
module system_descriptor_decoder (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata
);
    // ==========================================================
    // Control registers
    // ctrl: [0] start, [1] from local table, [2] privilege change, [3] if_in
    //       [5:4] target class: 0 none, 1 code segment, 2 task state segment
    logic [31:0] word_lo;
    logic [31:0] word_hi;
    logic [15:0] task_sel;
    logic [15:0] local_sel;
    logic        from_local;
    logic        priv_change;
    logic        if_in;
    logic [1:0]  target_kind;
    logic        start;
    sys_desc_pkg::check_state_t state;

    desc_field_if f ();
    assign f.word_lo = word_lo;
    assign f.word_hi = word_hi;

    desc_field_extract u_extract (
        .f (f)
    );

    // ==========================================================
    // Result registers
    sys_desc_pkg::desc_class_t dclass;
    logic        fault;
    logic [7:0]  fault_vec;
    logic        if_out;
    logic [15:0] entry_sel;
    logic [31:0] entry_ofs;
    logic [6:0]  copy_bytes;
    logic        copy_en;
    logic        is_busy;
    logic        is_ext;
    logic [1:0]  dpl_out;
    logic [31:0] base_out;
    logic [31:0] limit_out;

    // Type classification from the decoded type nibble
    logic is_tss;
    logic is_ldt;
    logic is_call;
    logic is_task;
    logic is_int;
    logic is_trap;
    logic is_bad_type;
    always_comb begin
        is_tss = 1'b0;
        is_ldt = 1'b0;
        is_call = 1'b0;
        is_task = 1'b0;
        is_int = 1'b0;
        is_trap = 1'b0;
        is_bad_type = 1'b0;
        case (f.dtype)
            `TYPE_TSS_LEG_AVAIL, `TYPE_TSS_LEG_BUSY,
            `TYPE_TSS_EXT_AVAIL, `TYPE_TSS_EXT_BUSY: is_tss = 1'b1;
            `TYPE_LDT: is_ldt = 1'b1;
            `TYPE_CALL_LEG, `TYPE_CALL_EXT: is_call = 1'b1;
            `TYPE_TASK_GATE: is_task = 1'b1;
            `TYPE_INT_LEG, `TYPE_INT_EXT: is_int = 1'b1;
            `TYPE_TRAP_LEG, `TYPE_TRAP_EXT: is_trap = 1'b1;
            default: is_bad_type = 1'b1;
        endcase
    end

    logic is_gate;
    assign is_gate = is_call | is_task | is_int | is_trap;

    // Fault decision, highest priority first
    logic       next_fault;
    logic [7:0] next_vec;
    always_comb begin
        next_fault = 1'b0;
        next_vec = 8'h00;
        if (f.sys_flag || is_bad_type) begin
            // Code/data entries are not system descriptors here
            next_fault = 1'b1;
            next_vec = `EXC_GENERAL;
        end else if (is_ldt && from_local) begin
            next_fault = 1'b1;
            next_vec = `EXC_GENERAL;
        end else if (!f.present) begin
            next_fault = 1'b1;
            next_vec = `EXC_NOT_PRESENT;
        end else if (is_task && target_kind != 2'd2) begin
            next_fault = 1'b1;
            next_vec = `EXC_GENERAL;
        end else if ((is_call || is_int || is_trap) && target_kind != 2'd1) begin
            next_fault = 1'b1;
            next_vec = `EXC_GENERAL;
        end
    end

    // ==========================================================
    // Register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            word_lo <= 32'h0;
            word_hi <= 32'h0;
            from_local <= 1'b0;
            priv_change <= 1'b0;
            if_in <= 1'b0;
            target_kind <= 2'd0;
            local_sel <= 16'h0;
        end else if (wr) begin
            case (addr)
                `ADDR_CTRL: begin
                    from_local <= wdata[1];
                    priv_change <= wdata[2];
                    if_in <= wdata[3];
                    target_kind <= wdata[5:4];
                end
                `ADDR_DESC_LO: word_lo <= wdata;
                `ADDR_DESC_HI: word_hi <= wdata;
                `ADDR_LOCAL_SEL: local_sel <= wdata[15:0];
                default: ;
            endcase
        end
    end

    // Start pulse from control bit 0
    always_ff @(posedge clk) begin
        if (rst) begin
            start <= 1'b0;
        end else begin
            start <= wr && addr == `ADDR_CTRL && wdata[0];
        end
    end

    // ==========================================================
    // Check sequencer: one cycle to latch, results stand until next start
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= sys_desc_pkg::ST_IDLE;
        end else begin
            case (state)
                sys_desc_pkg::ST_IDLE: if (start) state <= sys_desc_pkg::ST_CHECK;
                sys_desc_pkg::ST_CHECK: state <= sys_desc_pkg::ST_DONE;
                sys_desc_pkg::ST_DONE: if (start) state <= sys_desc_pkg::ST_CHECK;
                default: state <= sys_desc_pkg::ST_IDLE;
            endcase
        end
    end

    // Result capture in the check cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            dclass <= sys_desc_pkg::CLASS_NONE;
            fault <= 1'b0;
            fault_vec <= 8'h00;
            if_out <= 1'b0;
            entry_sel <= 16'h0;
            entry_ofs <= 32'h0;
            copy_bytes <= 7'h0;
            copy_en <= 1'b0;
            is_busy <= 1'b0;
            is_ext <= 1'b0;
            dpl_out <= 2'd0;
            base_out <= 32'h0;
            limit_out <= 32'h0;
        end else if (state == sys_desc_pkg::ST_CHECK) begin
            fault <= next_fault;
            fault_vec <= next_vec;
            is_ext <= ~f.legacy;
            base_out <= f.base;
            limit_out <= f.limit_bytes;
            is_busy <= is_tss & f.dtype[1];
            dpl_out <= is_ldt ? 2'd0 : f.descriptor_privilege_level;
            // A set system flag marks a code/data entry, so no system class is given
            dclass <= f.sys_flag ? sys_desc_pkg::CLASS_NONE :
                      is_tss ? sys_desc_pkg::CLASS_TSS :
                      is_ldt ? sys_desc_pkg::CLASS_LDT :
                      is_gate ? sys_desc_pkg::CLASS_GATE : sys_desc_pkg::CLASS_NONE;
            entry_sel <= is_gate ? f.dest_sel : 16'h0;
            entry_ofs <= (is_int || is_trap || is_call) ? f.dest_ofs : 32'h0;
            // Interrupt gate clears IF, trap gate passes it through
            if_out <= is_int ? 1'b0 : if_in;
            copy_en <= is_call && priv_change && !next_fault;
            // Parameter bytes: count times 2 or 4 by gate format
            copy_bytes <= (is_call && priv_change)
                          ? (f.dtype[3] ? {f.word_count, 2'b00} : {1'b0, f.word_count, 1'b0})
                          : 7'h0;
        end
    end

    // Current task selector updated by software when a task starts running
    always_ff @(posedge clk) begin
        if (rst) begin
            task_sel <= 16'h0;
        end else if (wr && addr == `ADDR_TASK_SEL) begin
            task_sel <= wdata[15:0];
        end
    end

    // ==========================================================
    // Read port, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0;
        end else if (rd) begin
            case (addr)
                `ADDR_CTRL: rdata <= {26'h0, target_kind, if_in, priv_change, from_local, 1'b0};
                `ADDR_DESC_LO: rdata <= word_lo;
                `ADDR_DESC_HI: rdata <= word_hi;
                `ADDR_TASK_SEL: rdata <= {16'h0, task_sel};
                `ADDR_LOCAL_SEL: rdata <= {16'h0, local_sel};
                `ADDR_STATUS: rdata <= {8'h00, fault_vec, 4'h0, dclass, dpl_out,
                                        is_busy, is_ext, if_out, copy_en, fault,
                                        state == sys_desc_pkg::ST_DONE};
                `ADDR_BASE: rdata <= base_out;
                `ADDR_LIMIT: rdata <= limit_out;
                `ADDR_ENTRY_SEL: rdata <= {16'h0, entry_sel};
                `ADDR_ENTRY_OFS: rdata <= entry_ofs;
                `ADDR_COPY_INFO: rdata <= {25'h0, copy_bytes};
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // ==========================================================
    // Checks; all but the last two properties start from the one check cycle
    sequence check_cycle_s;
        state == sys_desc_pkg::ST_CHECK;
    endsequence

    // Passes the type, flag and table tests but is marked absent
    sequence absent_seen_s;
        check_cycle_s ##0 (!f.sys_flag && !is_bad_type && !(is_ldt && from_local)
                           && !f.present);
    endsequence

    // Check step then done step, so software may read one cycle after the check
    sequence check_then_done_s;
        check_cycle_s ##1 (state == sys_desc_pkg::ST_DONE);
    endsequence

    absent_fault_a: assert property (@(posedge clk) disable iff (rst)
        absent_seen_s |=> (fault && fault_vec == `EXC_NOT_PRESENT))
        else $error("absent descriptor did not fault with 11");
    ldt_local_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 (is_ldt && from_local && !f.sys_flag) |=> fault)
        else $error("local table descriptor from local table accepted");
    int_if_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 is_int |=> !if_out)
        else $error("interrupt gate kept IF");
    trap_if_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 is_trap |=> (if_out == $past(if_in)))
        else $error("trap gate changed IF");
    task_target_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 (is_task && f.present && !f.sys_flag && target_kind != 2'd2)
        |=> (fault && fault_vec == `EXC_GENERAL))
        else $error("task gate bad target not 13");
    sys_flag_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 f.sys_flag |=> fault)
        else $error("system flag set not faulted");
    sys_class_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 f.sys_flag |=> (dclass == sys_desc_pkg::CLASS_NONE))
        else $error("system type decoded with system flag set");
    bad_type_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 is_bad_type |=> (fault && fault_vec == `EXC_GENERAL))
        else $error("invalid or reserved type not faulted with 13");
    copy_count_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 !is_call |=> (copy_bytes == 7'h0))
        else $error("word count used by non call gate");
    legacy_base_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 f.legacy |=> (base_out[31:24] == 8'h00))
        else $error("legacy base wider than 24 bits");
    ldt_dpl_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 is_ldt |=> (dpl_out == 2'd0))
        else $error("local table descriptor privilege not ignored");
    task_ofs_a: assert property (@(posedge clk) disable iff (rst)
        check_cycle_s ##0 is_task |=> (entry_ofs == 32'h0))
        else $error("task gate offset not ignored");
    // A start that lands in the check cycle is swallowed, so it is left out here
    check_order_a: assert property (@(posedge clk) disable iff (rst)
        (start && state != sys_desc_pkg::ST_CHECK) |=> check_then_done_s)
        else $error("check did not run in two steps");
    result_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state == sys_desc_pkg::ST_DONE && !start) |=> ($stable(fault_vec) && $stable(dclass)))
        else $error("results moved without a new start");
endmodule : system_descriptor_decoder

// ==== testbench/desc_table_model.sv ====
`timescale 1ns/1ps
// ====================================
// Descriptor tables held in system memory
module desc_table_model (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic        wtbl,
    input  wire logic [3:0]  idx,
    input  wire logic [63:0] went,
    input  wire logic        rtbl,
    output logic      [63:0] rent
);
    logic [63:0] glob_mem [16];
    logic [63:0] loc_mem  [16];

    // Empty slots hold a pattern, so a stale fetch is never a quiet zero
    initial begin
        for (int i = 0; i < 16; i++) begin
            glob_mem[i] = 64'ha5a5_5a5a_a5a5_5a5a;
            loc_mem[i]  = 64'h5a5a_a5a5_5a5a_a5a5;
        end
    end

    // Entries are kept exactly as software built them, flags included
    always @(posedge clk) begin
        if (we && wtbl) begin
            loc_mem[idx] <= went;
        end
        if (we && !wtbl) begin
            glob_mem[idx] <= went;
        end
    end

    // One 8-byte fetch from the table picked by the selector's table bit
    assign rent = rtbl ? loc_mem[idx] : glob_mem[idx];
endmodule : desc_table_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`include "sys_desc_defines.svh"
// ====================================
// Bench for the system descriptor decoder
module tb_top;
    localparam logic [31:0] all_ones = 32'hffff_ffff;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        we = 1'b0;
    logic        tbl = 1'b0;
    logic [3:0]  slot = 4'h0;
    logic [63:0] went = 64'h0;
    logic [63:0] rent;
    logic        rd_seen = 1'b0;
    logic [31:0] exp_q [$];
    logic [31:0] msk_q [$];
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          seed = 99;

    always #2 clk = ~clk;

    system_descriptor_decoder i_system_descriptor_decoder (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    desc_table_model i_desc_table_model (.clk(clk), .we(we), .wtbl(tbl), .idx(slot),
        .went(went), .rtbl(tbl), .rent(rent));

    // ====================================
    // Bus tasks and result checking
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        rd    <= 1'b0;
        @(posedge clk);
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        addr <= a;
        wr   <= 1'b0;
        rd   <= 1'b1;
        @(posedge clk);
    endtask : bus_rd

    task automatic bus_idle();
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus_idle

    task automatic cmp_read(input logic [31:0] got);
        logic [31:0] e;
        logic [31:0] m;
        cmp_count++;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
        m = (msk_q.size() > 0) ? msk_q.pop_front() : all_ones;
        if ((got & m) !== (e & m)) begin
            error_cnt++;
            $display("MISMATCH at %0t: read %h, expected %h under mask %h", $time, got, e, m);
        end
    endtask : cmp_read

    // Read data stands only in the cycle after the strobe, so it is taken there
    always @(posedge clk) begin
        if (rd_seen) begin
            cmp_read(rdata);
        end
        rd_seen <= rd;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Random fields; gate count padding kept clear, upper word forced per format
    function automatic logic [63:0] mk(input logic [3:0] t, input logic p, input logic ext);
        logic [31:0] h;
        logic [31:0] l;
        l = $random(seed);
        h = $random(seed);
        h[15:8] = {p, h[14:13], 1'b0, t};  // System flag built clear
        if (t inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf}) h[7:5] = 3'b000;
        h[31:16] = ext ? (h[31:16] | 16'h0100) : 16'h0;
        return {h, l};
    endfunction : mk

    // ====================================
    // One check: store, fetch, load, start, then read the results back to back
    task automatic run_check(input logic [63:0] ent, input logic from_loc,
                             input logic [1:0] kind, input logic if_in, input logic priv);
        logic [31:0] lo;
        logic [31:0] hi;
        logic [3:0]  t;
        logic [7:0]  vec;
        logic [3:0]  cls;
        logic        leg;
        logic        gate;
        logic        task_state_segment;
        logic        bad;
        logic        cpy;
        logic        ifo;
        logic [31:0] msk;
        logic [31:0] st;
        logic [31:0] base_e;
        logic [31:0] lim_e;
        logic [31:0] ofs_e;
        lo = ent[31:0];
        hi = ent[63:32];
        t = hi[11:8];
        leg = (hi[31:16] == 16'h0);
        gate = t inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf};
        task_state_segment = t inside {4'h1, 4'h3, 4'h9, 4'hb};
        bad = hi[12] || !(gate || task_state_segment || t == `TYPE_LDT);
        cpy = (t == `TYPE_CALL_LEG || t == `TYPE_CALL_EXT) && priv;
        ifo = (t == `TYPE_INT_LEG || t == `TYPE_INT_EXT) ? 1'b0 : if_in;
        if (bad || (t == `TYPE_LDT && from_loc)) vec = `EXC_GENERAL;
        else if (!hi[15]) vec = `EXC_NOT_PRESENT;
        else if (gate && kind != ((t == 4'h5) ? 2'd2 : 2'd1)) vec = `EXC_GENERAL;
        else vec = 8'h00;
        cls = bad ? 4'b0001 : gate ? 4'b1000 : task_state_segment ? 4'b0010 : 4'b0100;
        msk = (vec != 8'h00) ? 32'h00ff_0003 : 32'h0000_0ff7;
        if (bad || vec == 8'h00) msk[11:8] = 4'hf;
        if (vec == 8'h00 && t inside {4'h6, 4'h7, 4'he, 4'hf}) msk[3] = 1'b1;
        st = {8'h0, vec, 4'h0, cls, (t == `TYPE_LDT) ? 2'b00 : hi[14:13],
              (t == 4'h3 || t == 4'hb), !leg, ifo, cpy, (vec != 8'h00), 1'b1};
        base_e = leg ? {8'h0, hi[7:0], lo[31:16]} : {hi[31:24], hi[7:0], lo[31:16]};
        lim_e = hi[23] ? {hi[19:16], lo[15:0], 12'hfff} : {12'h0, hi[19:16], lo[15:0]};
        ofs_e = (t == 4'h5) ? 32'h0 : leg ? {16'h0, lo[15:0]} : {hi[31:16], lo[15:0]};
        we    <= 1'b1;
        tbl   <= from_loc;
        slot  <= slot + 4'h1;
        went  <= ent;
        @(posedge clk);
        we <= 1'b0;
        @(posedge clk);
        bus_wr(`ADDR_DESC_LO, rent[31:0]);
        bus_wr(`ADDR_DESC_HI, rent[63:32]);
        bus_wr(`ADDR_CTRL, {26'h0, kind, if_in, priv, from_loc, 1'b1});
        bus_idle();
        bus_idle();
        bus_rd(`ADDR_STATUS, st, msk);
        bus_rd(`ADDR_CTRL, {26'h0, kind, if_in, priv, from_loc, 1'b0}, all_ones);
        if (vec == 8'h00 && !gate) begin
            bus_rd(`ADDR_BASE, base_e, all_ones);
            bus_rd(`ADDR_LIMIT, leg ? {16'h0, lo[15:0]} : lim_e, all_ones);
        end
        if (vec == 8'h00 && gate) begin
            bus_rd(`ADDR_ENTRY_SEL, {16'h0, lo[31:16]}, all_ones);
            bus_rd(`ADDR_ENTRY_OFS, ofs_e, all_ones);
            bus_rd(`ADDR_COPY_INFO, cpy ? {25'h0, hi[4:0], 2'b00} >> (t == 4'h4) : 32'h0,
                   all_ones);
        end
        bus_idle();
    endtask : run_check

    // ====================================
    // Main sequence
    initial begin
        logic [63:0] e;
        logic [31:0] r;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus_rd(`ADDR_TASK_SEL, 32'h0, all_ones);
        r = $random(seed);
        bus_wr(`ADDR_TASK_SEL, {16'h0, r[15:0]});
        bus_rd(`ADDR_TASK_SEL, {16'h0, r[15:0]}, all_ones);
        bus_wr(`ADDR_LOCAL_SEL, {16'h0, r[31:16]});
        bus_rd(`ADDR_LOCAL_SEL, {16'h0, r[31:16]}, all_ones);
        bus_wr(`ADDR_STATUS, all_ones);
        bus_wr(4'hf, all_ones);
        bus_rd(`ADDR_STATUS, 32'h0000_0100, all_ones);  // Class reads none after reset
        bus_rd(4'hf, 32'h0, all_ones);
        bus_rd(`ADDR_TASK_SEL, {16'h0, r[15:0]}, all_ones);
        bus_idle();
        // Every type code, with the format matching the code
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            e = mk(i[3:0], 1'b1, !(i inside {1, 3, 4, 6, 7}));
            run_check(e, 1'b0, (i == 5) ? 2'd2 : 2'd1, r[0], r[1]);
        end
        e = mk(`TYPE_LDT, 1'b1, 1'b1);
        e[46:45] = 2'b11;
        run_check(e, 1'b0, 2'd0, 1'b0, 1'b0);
        run_check(e, 1'b1, 2'd0, 1'b0, 1'b0);
        e[47] = 1'b0;
        run_check(e, 1'b1, 2'd0, 1'b0, 1'b0);
        run_check(mk(`TYPE_CALL_EXT, 1'b0, 1'b1), 1'b0, 2'd2, 1'b0, 1'b1);
        run_check(mk(`TYPE_TSS_EXT_BUSY, 1'b0, 1'b1), 1'b0, 2'd0, 1'b0, 1'b0);
        e = mk(`TYPE_TSS_LEG_AVAIL, 1'b0, 1'b0);
        e[44] = 1'b1;
        run_check(e, 1'b0, 2'd0, 1'b0, 1'b0);
        run_check(mk(`TYPE_INT_EXT, 1'b1, 1'b1), 1'b0, 2'd2, 1'b1, 1'b0);
        run_check(mk(`TYPE_TASK_GATE, 1'b1, 1'b0), 1'b0, 2'd1, 1'b0, 1'b0);
        run_check(mk(`TYPE_TRAP_LEG, 1'b1, 1'b0), 1'b0, 2'd0, 1'b1, 1'b0);
        // Interrupt and trap gates entered with interrupts on, both formats
        for (int i = 0; i < 4; i++) begin
            e = mk({i[1], 2'b11, i[0]}, 1'b1, i[1]);
            run_check(e, 1'b0, 2'd1, 1'b1, 1'b0);
        end
        // Largest word count, both call gate formats, with and without a level change
        for (int i = 0; i < 4; i++) begin
            e = mk(i[0] ? `TYPE_CALL_EXT : `TYPE_CALL_LEG, 1'b1, i[0]);
            e[36:32] = 5'h1f;
            run_check(e, 1'b0, 2'd1, 1'b0, i[1]);
        end
        for (int i = 0; i < 2; i++) begin
            e = mk(`TYPE_TSS_EXT_AVAIL, 1'b1, 1'b1);
            e[55] = i[0];
            run_check(e, 1'b0, 2'd0, 1'b0, 1'b0);
        end
        // Only one limit bit set in the upper word still means the extended format
        e = mk(`TYPE_TSS_EXT_AVAIL, 1'b1, 1'b0);
        e[48] = 1'b1;
        run_check(e, 1'b0, 2'd0, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("MISMATCH at %0t: reads left unanswered", $time);
        end
        summarize();
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH at %0t: run did not finish in time", $time);
        summarize();
    end
endmodule : tb_top
